/* adc_readout_ctrl.sv */
// Purpose: Conversion control and result readout, parallel or serial.
// Assumes: All pin inputs synchronous to clock_i; sar_code_i is valid
//          at end of conversion; pin mode decoding is done outside.
// Notes:   Results pass through an eight-word FIFO; a full FIFO refuses
//          new convert strobes until the host reads.

`timescale 1ns/1ps

module adc_readout_ctrl
    import adc_readout_pkg::*;
#(
    parameter int RES_W       = RES_BITS,
    parameter int DEPTH       = FIFO_DEPTH,
    parameter int CONV_CYCLES = CONV_CYC
) (
    input  wire logic             clock_i,                // 100 MHz clock
    input  wire logic             srst_i,                 // Sync reset
    input  wire logic             reset_pulse_i,          // Device reset pin
    input  wire logic             convert_strobe_n_i,     // Start, falling
    input  wire logic             cs_n_i,                 // Chip select
    input  wire logic             rd_n_i,                 // Parallel read
    input  wire logic             serial_mode_i,          // 1 = serial
    input  wire logic             master_mode_i,          // 1 = drive clock
    input  wire logic             read_after_convert_i,   // Master timing
    input  wire logic [1:0]       clock_divider_select_i, // Clock divider
    input  wire logic [RES_W-1:0] sar_code_i,             // Core result
    input  wire logic             ext_sclk_i,             // Slave clock
    input  wire logic             serial_data_in_i,       // Daisy chain in
    output logic                  busy_o,                 // Converting
    output logic                  convert_ready_o,        // FIFO has room
    output logic      [RES_W-1:0] data_o,                 // Parallel data
    output logic                  data_oe_o,              // Parallel drive
    output logic                  sclk_o,                 // Master clock
    output logic                  sclk_oe_o,              // Clock drive
    output logic                  sync_o,                 // Frame sync
    output logic                  sync_oe_o,              // Sync drive
    output logic                  serial_data_out_o,      // Serial data
    output logic                  serial_data_out_oe_o    // Data drive
);

    typedef struct packed {
        conv_state_t      st;
        frame_state_t     fr;
        logic [7:0]       cnt;
        logic [5:0]       fcnt;
        logic [4:0]       bits;
        logic [1:0]       div;
        logic             cnv_q;
        logic             ext_q;
        logic             busy;
        logic [RES_W-1:0] hold;
        logic             stale;
        logic [RES_W-1:0] shreg;
        logic             slv_act;
        logic             sclk;
        logic             sync;
        logic             sdo;
        logic             par_oe;
        logic             mst_oe;
        logic             sdo_oe;
    } ctrl_st_t;

    ctrl_st_t         s;
    ctrl_st_t         next_s;
    logic             rst;
    logic             fifo_push;
    logic             fifo_valid;
    logic [RES_W-1:0] fifo_data;
    logic             cnv_fall;
    logic             ext_fall;
    logic             rac;
    logic             frame_done;

    // Clock high phase in cycles; the extra odd cycle goes high
    function automatic logic [5:0] sclk_hi(input logic [1:0] d);
        int p;
        p = ns_to_cyc(T_SCLK_MIN_NS[d]);
        return 6'(p - p / 2);
    endfunction

    // Clock low phase in cycles
    function automatic logic [5:0] sclk_lo(input logic [1:0] d);
        int p;
        p = ns_to_cyc(T_SCLK_MIN_NS[d]);
        return 6'(p / 2);
    endfunction

    // Device reset pin clears the same state as the system reset
    assign rst = srst_i | reset_pulse_i;

    assign rac        = serial_mode_i & master_mode_i & read_after_convert_i;
    assign cnv_fall   = s.cnv_q & ~convert_strobe_n_i;
    assign ext_fall   = s.ext_q & ~ext_sclk_i;
    assign fifo_push  = (s.st == CV_CONV) && (s.cnt == '0);
    assign frame_done = (s.fr == FR_HOLD) && (s.fcnt == '0);

    // Results wait here until the output register is free
    sample_fifo #(
        .WIDTH (RES_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .srst_i      (rst),
        .in_valid_i  (fifo_push),
        .in_ready_o  (convert_ready_o),
        .in_data_i   (sar_code_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (s.stale),
        .out_data_o  (fifo_data)
    );

    // Whole next-state function
    always_comb
    begin
        next_s       = s;
        next_s.cnv_q = convert_strobe_n_i;
        next_s.ext_q = ext_sclk_i;

        // Output enables, registered so each follows its strobe in one cycle
        next_s.par_oe = ~serial_mode_i & ~cs_n_i & ~rd_n_i;
        next_s.mst_oe = serial_mode_i & master_mode_i & ~cs_n_i;
        next_s.sdo_oe = serial_mode_i & ~cs_n_i;

        // A parallel read that ends marks the held result as consumed
        if (s.par_oe & ~next_s.par_oe)
        begin
            next_s.stale = 1'b1;
        end

        // Conversion sequencer
        case (s.st)
            CV_IDLE:
            begin
                // A full FIFO refuses the strobe; the host sees convert_ready_o
                if (cnv_fall & convert_ready_o)
                begin
                    next_s.busy = 1'b1;
                    next_s.cnt  = 8'(CONV_CYCLES - 1);
                    next_s.st   = CV_CONV;
                    // Read during convert ships the previous result now
                    if (serial_mode_i & master_mode_i & ~read_after_convert_i
                        & (s.fr == FR_OFF))
                    begin
                        next_s.fr    = FR_LEAD;
                        next_s.div   = 2'b00;
                        next_s.fcnt  = 6'(ns_to_cyc(T_LEAD_MIN_NS[0]) - 1);
                        next_s.sync  = 1'b1;
                        next_s.sclk  = 1'b0;
                        next_s.shreg = s.hold;
                        next_s.sdo   = s.hold[RES_W-1];
                        next_s.bits  = 5'(RES_W - 1);
                        next_s.stale = 1'b1;
                    end
                end
            end
            CV_CONV:
            begin
                // Result enters the FIFO on the last conversion cycle
                next_s.cnt = s.cnt - 1'b1;
                if (s.cnt == '0)
                begin
                    next_s.st = CV_LOAD;
                end
            end
            CV_LOAD:
            begin
                // Newest result is in the output register once all drained
                if (~fifo_valid & ~s.stale)
                begin
                    if (rac)
                    begin
                        if (s.fr == FR_OFF)
                        begin
                            next_s.fr    = FR_LEAD;
                            next_s.div   = clock_divider_select_i;
                            next_s.fcnt  = 6'(ns_to_cyc(
                                T_LEAD_MIN_NS[clock_divider_select_i]) - 1);
                            next_s.sync  = 1'b1;
                            next_s.sclk  = 1'b0;
                            next_s.shreg = s.hold;
                            next_s.sdo   = s.hold[RES_W-1];
                            next_s.bits  = 5'(RES_W - 1);
                            next_s.stale = 1'b1;
                            next_s.st    = CV_FRAME;
                        end
                    end
                    else
                    begin
                        // Data stands this long before busy drops
                        next_s.cnt = 8'(DV_BUSY_CYC - 1);
                        next_s.st  = CV_SETTLE;
                    end
                end
            end
            CV_SETTLE:
            begin
                next_s.cnt = s.cnt - 1'b1;
                if (s.cnt == '0)
                begin
                    next_s.busy = 1'b0;
                    next_s.st   = CV_IDLE;
                end
            end
            CV_FRAME:
            begin
                if (frame_done)
                begin
                    next_s.cnt = 8'(SYNC_BUSY_CYC - 1);
                    next_s.st  = CV_SETTLE;
                end
            end
            default:
            begin
                next_s.st = CV_IDLE;
            end
        endcase

        // Master serial frame engine; data changes on the falling clock
        case (s.fr)
            FR_OFF:
            begin
                next_s.sclk = 1'b0;
            end
            FR_LEAD:
            begin
                next_s.fcnt = s.fcnt - 1'b1;
                if (s.fcnt == '0)
                begin
                    next_s.sclk = 1'b1;
                    next_s.fcnt = sclk_hi(s.div) - 1'b1;
                    next_s.fr   = FR_SHIFT;
                end
            end
            FR_SHIFT:
            begin
                next_s.fcnt = s.fcnt - 1'b1;
                if (s.fcnt == '0)
                begin
                    if (s.sclk)
                    begin
                        next_s.sclk = 1'b0;
                        next_s.fcnt = sclk_lo(s.div) - 1'b1;
                        if (s.bits == '0)
                        begin
                            next_s.fr   = FR_HOLD;
                            next_s.fcnt = 6'(ns_to_cyc(T_TAIL_MIN_NS[s.div]) - 1);
                        end
                        else
                        begin
                            next_s.shreg = {s.shreg[RES_W-2:0], serial_data_in_i};
                            next_s.sdo   = s.shreg[RES_W-2];
                            next_s.bits  = s.bits - 1'b1;
                        end
                    end
                    else
                    begin
                        next_s.sclk = 1'b1;
                        next_s.fcnt = sclk_hi(s.div) - 1'b1;
                    end
                end
            end
            FR_HOLD:
            begin
                next_s.fcnt = s.fcnt - 1'b1;
                if (s.fcnt == '0)
                begin
                    next_s.sync = 1'b0;
                    next_s.fr   = FR_OFF;
                end
            end
            default:
            begin
                next_s.fr = FR_OFF;
            end
        endcase

        // Slave serial: select loads the shifter, external falls shift it
        if (serial_mode_i & ~master_mode_i)
        begin
            if (cs_n_i)
            begin
                next_s.slv_act = 1'b0;
            end
            else if (~s.slv_act)
            begin
                next_s.slv_act = 1'b1;
                next_s.shreg   = s.hold;
                next_s.sdo     = s.hold[RES_W-1];
                next_s.bits    = 5'(RES_W - 1);
                next_s.stale   = 1'b1;
            end
            else if (ext_fall & (s.bits != '0))
            begin
                // One cycle after the sampled edge keeps data within its window
                next_s.shreg = {s.shreg[RES_W-2:0], serial_data_in_i};
                next_s.sdo   = s.shreg[RES_W-2];
                next_s.bits  = s.bits - 1'b1;
            end
        end

        // Drain last so a fresh load wins over any consume in this cycle
        if (s.stale & fifo_valid)
        begin
            next_s.hold  = fifo_data;
            next_s.stale = 1'b0;
        end
    end

    // State register; nothing is held across a reset
    always_ff @(posedge clock_i)
    begin
        if (rst)
        begin
            s       <= '0;
            s.st    <= CV_IDLE;
            s.fr    <= FR_OFF;
            s.cnv_q <= 1'b1;
            s.stale <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs come straight from the state register
    assign busy_o               = s.busy;
    assign data_o               = s.hold;
    assign data_oe_o            = s.par_oe;
    assign sclk_o               = s.sclk;
    assign sclk_oe_o            = s.mst_oe;
    assign sync_o               = s.sync;
    assign sync_oe_o            = s.mst_oe;
    assign serial_data_out_o    = s.sdo;
    assign serial_data_out_oe_o = s.sdo_oe;

endmodule

/* adc_readout_pkg.sv */
// Purpose: Shared constants and state types for the converter readout block.
// Assumes: 100 MHz system clock; all times below are in nanoseconds.
// Notes:   Cycle counts derive from the times; least times round up.

package adc_readout_pkg;

    localparam int CLK_NS     = 10;
    localparam int RES_BITS   = 18;
    localparam int FIFO_DEPTH = 8;

    // Busy window outside master read-after-convert, and conversion margin
    localparam int T_BUSY_MAX_NS   = 1500;
    localparam int CONV_MARGIN_CYC = 8;
    localparam int CONV_CYC        = T_BUSY_MAX_NS / CLK_NS - CONV_MARGIN_CYC;

    // Least delays around the busy fall
    localparam int T_EOC_BUSY_NS  = 10;
    localparam int T_DV_BUSY_NS   = 20;
    localparam int T_SYNC_BUSY_NS = 25;

    // Serial clock timing per divider setting 00, 01, 10, 11
    localparam int T_SCLK_MIN_NS [4] = '{25, 60, 120, 240};
    localparam int T_LEAD_MIN_NS [4] = '{3, 17, 17, 17};
    localparam int T_TAIL_MIN_NS [4] = '{3, 60, 140, 300};

    // Ceiling division of a time into clock cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int EOC_BUSY_CYC  = ns_to_cyc(T_EOC_BUSY_NS);
    localparam int DV_BUSY_CYC   = ns_to_cyc(T_DV_BUSY_NS);
    localparam int SYNC_BUSY_CYC = ns_to_cyc(T_SYNC_BUSY_NS);

    typedef enum logic [2:0] {
        CV_IDLE   = 3'b000,
        CV_CONV   = 3'b001,
        CV_LOAD   = 3'b010,
        CV_SETTLE = 3'b011,
        CV_FRAME  = 3'b100
    } conv_state_t;

    typedef enum logic [1:0] {
        FR_OFF   = 2'b00,
        FR_LEAD  = 2'b01,
        FR_SHIFT = 2'b10,
        FR_HOLD  = 2'b11
    } frame_state_t;

endpackage

/* adc_readout_sva.sv */
// Purpose: Port timing checks for the converter readout block.
// Assumes: One clock; either reset input clears the block.
// Notes:   Serial figures are counted in 10 ns cycles.

`timescale 1ns/1ps

module adc_readout_sva #(
    parameter int RES_W = 18
) (
    input wire logic             clock_i,                // Clock
    input wire logic             srst_i,                 // Reset
    input wire logic             reset_pulse_i,          // Reset pin
    input wire logic             convert_strobe_n_i,     // Start
    input wire logic             cs_n_i,                 // Select
    input wire logic             rd_n_i,                 // Read
    input wire logic             serial_mode_i,          // Serial
    input wire logic             master_mode_i,          // Master
    input wire logic             read_after_convert_i,   // After mode
    input wire logic [1:0]       clock_divider_select_i, // Divider
    input wire logic             busy_o,                 // Busy
    input wire logic             convert_ready_o,        // Room
    input wire logic [RES_W-1:0] data_o,                 // Data
    input wire logic             data_oe_o,              // Data drive
    input wire logic             sclk_o,                 // Clock out
    input wire logic             sclk_oe_o,              // Clock drive
    input wire logic             sync_o,                 // Sync
    input wire logic             sync_oe_o,              // Sync drive
    input wire logic             serial_data_out_oe_o    // Data drive
);
    localparam int LO_CYC [4]   = '{3, 6, 12, 24};
    localparam int HI_CYC [4]   = '{4, 8, 16, 32};
    localparam int TAIL_CYC [4] = '{1, 6, 14, 30};
    localparam int BUSY_MAX [4] = '{225, 300, 450, 750};

    int         busy_cnt;   // Cycles busy has stood high
    int         gap;        // Cycles since the last clock rise
    int         since_fall; // Cycles since the last clock fall
    bit         had_rise;   // A rise already seen in this frame
    logic       rac;        // Master read after convert
    logic [1:0] div;        // Divider in force

    // Read during convert always runs at the fastest setting
    assign rac = serial_mode_i && master_mode_i && read_after_convert_i;
    assign div = rac ? clock_divider_select_i : 2'h0;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i || reset_pulse_i);

    // Long windows are counted here so the properties stay cheap
    always_ff @(posedge clock_i)
    begin
        busy_cnt   <= busy_o ? busy_cnt + 1 : 0;
        gap        <= $rose(sclk_o) ? 1 : gap + 1;
        since_fall <= $fell(sclk_o) ? 0 : since_fall + 1;
        had_rise   <= sync_o && (had_rise || $rose(sclk_o));
    end

    a_busy_rise: assert property ($past(convert_strobe_n_i) && !convert_strobe_n_i &&
        !busy_o && convert_ready_o |=> busy_o) else $error("busy missed the strobe");
    a_busy_short: assert property (busy_o && !rac |-> busy_cnt < 150)
        else $error("busy too long");
    a_busy_rac: assert property (busy_o && rac |-> busy_cnt < BUSY_MAX[div])
        else $error("busy too long after convert");
    a_data_settled: assert property ($fell(busy_o) && !serial_mode_i |->
        data_o == $past(data_o, 2)) else $error("data late before busy fall");
    a_bus_drive: assert property (!cs_n_i && !rd_n_i && !serial_mode_i |=> data_oe_o)
        else $error("bus not driven");
    a_clock_drive: assert property (serial_mode_i && master_mode_i && !cs_n_i |=>
        sclk_oe_o && sync_oe_o) else $error("clock not driven");
    a_pins_release: assert property (cs_n_i |=>
        !sclk_oe_o && !sync_oe_o && !serial_data_out_oe_o) else $error("pins not released");
    a_clock_period: assert property ($rose(sclk_o) && had_rise |->
        gap >= LO_CYC[div] && gap <= HI_CYC[div]) else $error("clock period out of range");
    a_sync_lead: assert property ($rose(sync_o) |-> !sclk_o ##1 (div == 2'h0 || !sclk_o))
        else $error("clock edge too close to sync");
    a_sync_tail: assert property ($fell(sync_o) |-> since_fall + 1 >= TAIL_CYC[div])
        else $error("sync fell too early");
    a_busy_after_sync: assert property ($fell(sync_o) && rac |-> busy_o [*3] ##1 !busy_o)
        else $error("busy fall not after sync");
endmodule

bind adc_readout_ctrl adc_readout_sva #(.RES_W(RES_W)) u_sva (
    .clock_i(clock_i), .srst_i(srst_i), .reset_pulse_i(reset_pulse_i),
    .convert_strobe_n_i(convert_strobe_n_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i),
    .serial_mode_i(serial_mode_i), .master_mode_i(master_mode_i),
    .read_after_convert_i(read_after_convert_i),
    .clock_divider_select_i(clock_divider_select_i), .busy_o(busy_o),
    .convert_ready_o(convert_ready_o), .data_o(data_o), .data_oe_o(data_oe_o),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o),
    .serial_data_out_oe_o(serial_data_out_oe_o)
);

/* sample_fifo.sv */
// Purpose: Synchronous FIFO holding finished conversion results.
// Assumes: Single clock; reset clears contents.
// Notes:   Full and empty are exact; ready drops only when full.

`timescale 1ns/1ps

module sample_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input  wire logic             clock_i,     // System clock
    input  wire logic             srst_i,      // Synchronous reset, flushes
    input  wire logic             in_valid_i,  // Write request
    output logic                  in_ready_o,  // Space available
    input  wire logic [WIDTH-1:0] in_data_i,   // Write word
    output logic                  out_valid_o, // Word available
    input  wire logic             out_ready_i, // Reader takes word
    output logic      [WIDTH-1:0] out_data_o   // Head word
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_st_t;

    fifo_st_t s;
    fifo_st_t next_s;
    logic     push;
    logic     pop;

    // Handshakes straight from the count
    assign in_ready_o  = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s.cnt != '0);
    assign out_data_o  = s.mem[s.rp];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // Pointer wrap works for any depth, not only powers of two
    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
        end
        if (pop)
        begin
            next_s.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
        end
        if (push & ~pop)
        begin
            next_s.cnt = s.cnt + 1'b1;
        end
        else if (pop & ~push)
        begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    // State register
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

endmodule

/* serial_host.sv */
// Purpose: Host side of the serial link: clocks a slave, takes bits.
// Assumes: Driven from the system clock edge.
// Notes:   Slave clock is 50 ns, high 20 ns, and idles low.

`timescale 1ns/1ps

module serial_host (
    input  wire logic        clock_i,    // System clock
    input  wire logic        go_i,       // Run slave clock
    input  wire logic        sclk_i,     // Device clock
    input  wire logic        sync_i,     // Device sync
    input  wire logic        sdo_i,      // Data wire
    output logic             ext_sclk_o, // Slave clock
    output logic      [17:0] word_o,     // Bits, MSB first
    output int               bits_o      // Bits taken
);
    int   ph = 0;        // Phase in a slave period
    logic sclk_q = 1'b0; // Device clock last edge
    logic sync_q = 1'b0; // Sync last edge
    logic go_q = 1'b0;   // Go last edge

    initial
    begin
        ext_sclk_o = 1'b0;
        word_o = 18'h00000;
        bits_o = 0;
    end

    // A new frame or slave run clears the count; bits taken on rising clocks
    always @(posedge clock_i)
    begin
        sclk_q <= sclk_i;
        sync_q <= sync_i;
        go_q <= go_i;
        ph <= (!go_i || ph == 4) ? 0 : ph + 1;
        ext_sclk_o <= go_i && bits_o < 18 && (ph == 2 || ph == 3);
        if ((sync_i && !sync_q) || (go_i && !go_q))
            bits_o <= 0;
        if ((go_i && ph == 2 && bits_o < 18) || (sync_i && sclk_i && !sclk_q))
        begin
            word_o <= {word_o[16:0], sdo_i};
            bits_o <= bits_o + 1;
        end
    end
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the converter readout block.
// Assumes: Conversion shortened to 10 cycles.
// Notes:   A queue holds results not yet read by the host.

`timescale 1ns/1ps

module testbench;
    localparam int CONV = 10;
    localparam int BUSY_MAX [4] = '{225, 300, 450, 750};

    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        reset_pulse_i = 1'b0;
    logic        strobe_n = 1'b1;
    logic        cs_n = 1'b1;
    logic        rd_n = 1'b1;
    logic        serial = 1'b0;
    logic        master = 1'b0;
    logic        rac = 1'b0;
    logic        go = 1'b0;
    logic [1:0]  div = 2'h0;
    logic [17:0] code = 18'h00000;
    logic [17:0] prev;
    logic [17:0] data;
    logic [17:0] word;
    logic        busy, ready, data_oe, sclk, sclk_oe, sync, sync_oe, sdo, sdo_oe, ext_sclk;
    logic        sdo_wire;
    int          bits;
    int          n;
    int          failures = 0;
    int          checks_done = 0;
    logic [17:0] q[$];

    // Released data wire shows the inverse rather than a stale bit
    assign sdo_wire = sdo_oe ? sdo : ~sdo;

    always #5 clock_i = ~clock_i;

    adc_readout_ctrl #(.CONV_CYCLES(CONV)) u_dut (
        .clock_i(clock_i), .srst_i(srst_i), .reset_pulse_i(reset_pulse_i),
        .convert_strobe_n_i(strobe_n), .cs_n_i(cs_n), .rd_n_i(rd_n),
        .serial_mode_i(serial), .master_mode_i(master), .read_after_convert_i(rac),
        .clock_divider_select_i(div), .sar_code_i(code), .ext_sclk_i(ext_sclk),
        .serial_data_in_i(1'b0), .busy_o(busy), .convert_ready_o(ready),
        .data_o(data), .data_oe_o(data_oe), .sclk_o(sclk), .sclk_oe_o(sclk_oe),
        .sync_o(sync), .sync_oe_o(sync_oe), .serial_data_out_o(sdo),
        .serial_data_out_oe_o(sdo_oe)
    );

    serial_host u_host (
        .clock_i(clock_i), .go_i(go), .sclk_i(sclk), .sync_i(sync), .sdo_i(sdo_wire),
        .ext_sclk_o(ext_sclk), .word_o(word), .bits_o(bits)
    );

    task automatic tick();
        @(posedge clock_i);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Bounded waits; running out ends the run as a failure
    task automatic wait_idle(output int cnt);
        cnt = 0;
        while (busy === 1'b1 && cnt < 1000)
        begin
            tick();
            cnt++;
        end
        if (busy !== 1'b0)
        begin
            failures++;
            results();
        end
    endtask

    task automatic await_word(input logic [17:0] exp);
        int k;
        k = 0;
        while (bits < 18 && k < 1000)
        begin
            tick();
            k++;
        end
        if (bits < 18)
        begin
            failures++;
            results();
        end
        check(word, exp);
    endtask

    task automatic reset_dut(input bit by_pin);
        srst_i = !by_pin;
        reset_pulse_i = by_pin;
        repeat (8) tick();
        srst_i = 1'b0;
        reset_pulse_i = 1'b0;
        q.delete();
        repeat (2) tick();
        check({busy, ready, data_oe, data}, {3'h2, 18'h00000});
    endtask

    // One conversion with a fresh code; strobes kept at least 178 cycles apart
    task automatic convert(input int limit, input bit finish);
        int cnt;
        code = 18'($urandom);
        q.push_back(code);
        strobe_n = 1'b0;
        tick();
        strobe_n = 1'b1;
        repeat (2) tick();
        check(busy, 1'b1);
        if (finish)
        begin
            wait_idle(cnt);
            check(cnt + 2 >= CONV + 2 && cnt + 2 <= limit, 1'b1);
            check(data, q[$]);
            repeat (175 - cnt) tick();
        end
    endtask

    task automatic bus_read();
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (2) tick();
        check({data_oe, data}, {1'b1, q.pop_front()});
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (3) tick();
        check(data_oe, 1'b0);
    endtask

    initial
    begin
        void'($urandom(32'hD1436E03));
        reset_dut(1'b0);
        // Parallel: each result read before the next conversion
        repeat (3)
        begin
            convert(150, 1'b1);
            bus_read();
        end
        // A second result waits behind an unread one
        convert(150, 1'b1);
        convert(150, 1'b0);
        repeat (30) tick();
        check({busy, data}, {1'b1, q[0]});
        bus_read();
        wait_idle(n);
        check(data, q[0]);
        bus_read();
        // Master read after convert at every divider
        serial = 1'b1;
        master = 1'b1;
        rac = 1'b1;
        cs_n = 1'b0;
        reset_dut(1'b1);
        for (int d = 0; d < 4; d++)
        begin
            div = 2'(d);
            convert(BUSY_MAX[d], 1'b1);
            await_word(q.pop_front());
        end
        cs_n = 1'b1;
        repeat (2) tick();
        check({sclk_oe, sync_oe, sdo_oe}, 3'h0);
        cs_n = 1'b0;
        repeat (2) tick();
        check({sclk_oe, sync_oe}, 2'h3);
        // Read during convert sends the result before
        rac = 1'b0;
        prev = code;
        convert(150, 1'b1);
        await_word(prev);
        // Slave readout on the host's clock
        master = 1'b0;
        cs_n = 1'b1;
        reset_dut(1'b0);
        convert(150, 1'b1);
        cs_n = 1'b0;
        repeat (2) tick();
        go = 1'b1;
        tick();
        await_word(q.pop_front());
        go = 1'b0;
        cs_n = 1'b1;
        tick();
        results();
    end
endmodule
